/* core/buck_fault_supervisor.sv */
// fault, output-ok and discharge sequencing for the step-down converter
`timescale 1ns/1ns
// Operation
// - output-ok rises 1.06 ms after both soft-start ramps complete
// - internal soft-start ramp lasts 2 ms
// - external soft-start done when feedback reaches reference minus 50 mV
// - feedback below 80% or above 116% latches output-ok low after 2 us
// - latched-low output-ok stays low until enable toggle or supply reset
// - output-ok low by default, full function only after soft-start
// - feedback below 80% for 68 us latches both drivers off
// - undervoltage detection inactive until soft-start completes
// - above 116%: high side latched off, low side on until negative clamp
// - at clamp: one high-side on-time, repeat until 68 us undervoltage
// - latched faults clear only by supply reset or enable toggle
// - undervoltage timer restarts from zero if output recovers
// - early overvoltage at 105% is non-latching, raises no fault
// - early overvoltage forces continuous mode with negative clamp active
// - discharge: switches off, discharge on until feedback below 90 mV
// - discharge on enable low, thermal trip, bias or input lockout
// - bias lockout shuts off and resumes without latching
// - input lockout stops switching, discharges soft-start, then restarts
// - thermal trip stops switching, discharges soft-start, restarts fresh
// - skip operation when mode strap selects it
// - forced continuous operation when mode strap selects it
// - skip mode turns low side off at zero inductor current
module buck_fault_supervisor
   import fault_sup_pkg::*;
#(
   parameter int PG_DELAY = PG_DELAY_CYC,
   parameter int SS_RAMP  = SS_RAMP_CYC
) (
   input  wire logic      sys_clk,
   input  wire logic      nrst,
   input  wire logic      enable,
   input  wire logic      bias_lockout,
   input  wire logic      input_lockout,
   input  wire logic      thermal_trip,
   input  wire logic      skip_mode_sel,
   input  wire fb_cmp_t   fb_cmp,
   output logic           output_ok_flag_o,
   output logic           output_ok_flag_oe_n,
   output gate_cmd_t      gate_cmd,
   output logic           discharge_on,
   output logic           ss_pin_discharge,
   output logic           forced_continuous_operation,
   output logic           undervoltage_trip,
   output logic           overvoltage_trip,
   output logic           early_overvoltage_guard
);
   fb_cmp_t fb_s;
   logic    run_ok;
   logic    fault_ff;
   logic    ss_int_done;
   logic    pg_qual_done;
   logic    pg_fault_done;
   logic    uv_done;
   logic    ok_latch_low_ff;
   logic    enable_d_ff;
   logic    bias_d_ff;
   logic    in_d_ff;
   logic    therm_d_ff;
   logic    dis_ff;
   logic    hs_pulse_ff;
   logic    ss_ext_done;
   logic    ss_done;

   sync_stage #(.W(SYNC_W)) u_sync (
      .sys_clk (sys_clk),
      .nrst    (nrst),
      .d       (fb_cmp),
      .q       (fb_s)
   );

   // run only while enabled and free of lockouts; a dropout restarts soft-start
   assign run_ok = enable && !bias_lockout && !input_lockout && !thermal_trip;

   delay_timer #(.W(CNT_W), .LEN(SS_RAMP)) u_ss (
      .sys_clk (sys_clk),
      .nrst    (nrst),
      .start   (run_ok),
      .done    (ss_int_done)
   );

   assign ss_ext_done = fb_s.near_ref;
   assign ss_done     = ss_int_done && ss_ext_done;

   delay_timer #(.W(CNT_W), .LEN(PG_DELAY)) u_pg (
      .sys_clk (sys_clk),
      .nrst    (nrst),
      .start   ((ss_done || pg_qual_done) && run_ok),
      .done    (pg_qual_done)
   );

   delay_timer #(.W(CNT_W), .LEN(PG_FAULT_CYC)) u_pgf (
      .sys_clk (sys_clk),
      .nrst    (nrst),
      .start   (pg_qual_done && (fb_s.below_uv || fb_s.above_ov)),
      .done    (pg_fault_done)
   );

   // uv timer gated by soft-start done; recovery clears it to zero
   delay_timer #(.W(CNT_W), .LEN(UV_DELAY_CYC)) u_uv (
      .sys_clk (sys_clk),
      .nrst    (nrst),
      .start   (ss_int_done && fb_s.below_uv),
      .done    (uv_done)
   );

   always_ff @(posedge sys_clk) begin
      if (!nrst) begin
         enable_d_ff <= 1'b0;
         bias_d_ff   <= 1'b1;
         in_d_ff     <= 1'b1;
         therm_d_ff  <= 1'b0;
      end else begin
         enable_d_ff <= enable;
         bias_d_ff   <= bias_lockout;
         in_d_ff     <= input_lockout;
         therm_d_ff  <= thermal_trip;
      end
   end

   // latched faults: only enable low (toggle) or reset clears them
   always_ff @(posedge sys_clk) begin
      if (!nrst || !enable) begin
         undervoltage_trip <= 1'b0;
         overvoltage_trip  <= 1'b0;
         fault_ff          <= 1'b0;
      end else begin
         if (uv_done) begin
            undervoltage_trip <= 1'b1;
            fault_ff          <= 1'b1;
         end
         if (ss_int_done && fb_s.above_ov) begin
            overvoltage_trip <= 1'b1;
         end
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!nrst || !enable) begin
         ok_latch_low_ff <= 1'b0;
      end else if (pg_fault_done) begin
         ok_latch_low_ff <= 1'b1;
      end
   end

   // open-drain: oe_n low pulls the pin low; default pulled low
   always_ff @(posedge sys_clk) begin
      if (!nrst) begin
         output_ok_flag_o    <= 1'b0;
         output_ok_flag_oe_n <= 1'b0;
      end else begin
         output_ok_flag_o    <= 1'b0;
         output_ok_flag_oe_n <= pg_qual_done && !ok_latch_low_ff && run_ok && !fault_ff;
      end
   end

   // discharge mode entered on falling enable or any shutdown event
   always_ff @(posedge sys_clk) begin
      if (!nrst) begin
         dis_ff <= 1'b0;
      end else if ((enable_d_ff && !enable) || (!therm_d_ff && thermal_trip)
                   || (!bias_d_ff && bias_lockout) || (!in_d_ff && input_lockout)) begin
         dis_ff <= 1'b1;
      end else if (fb_s.below_dis || run_ok) begin
         dis_ff <= 1'b0;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!nrst) begin
         discharge_on     <= 1'b0;
         ss_pin_discharge <= 1'b1;
      end else begin
         discharge_on     <= dis_ff && !fb_s.below_dis;
         ss_pin_discharge <= !run_ok;
      end
   end

   // overvoltage pull-down: one high-side on-time after each clamp hit
   always_ff @(posedge sys_clk) begin
      if (!nrst || !overvoltage_trip) begin
         hs_pulse_ff <= 1'b0;
      end else if (fb_s.neg_clamp && !hs_pulse_ff) begin
         hs_pulse_ff <= 1'b1;
      end else if (fb_s.on_time_done) begin
         hs_pulse_ff <= 1'b0;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!nrst) begin
         early_overvoltage_guard     <= 1'b0;
         forced_continuous_operation <= 1'b0;
      end else begin
         early_overvoltage_guard     <= run_ok && fb_s.above_early;
         forced_continuous_operation <= !skip_mode_sel || fb_s.above_early;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!nrst) begin
         gate_cmd <= '{hs_on: 1'b0, ls_on: 1'b0, hs_latch_off: 1'b1, ls_latch_off: 1'b1};
      end else if (fault_ff || dis_ff || !run_ok) begin
         gate_cmd <= '{hs_on: 1'b0, ls_on: 1'b0, hs_latch_off: 1'b1, ls_latch_off: 1'b1};
      end else if (overvoltage_trip) begin
         gate_cmd <= '{hs_on: hs_pulse_ff, ls_on: !hs_pulse_ff && !fb_s.neg_clamp,
                       hs_latch_off: !hs_pulse_ff, ls_latch_off: 1'b0};
      end else begin
         // ls off at zero current only in skip mode without early overvoltage
         gate_cmd <= '{hs_on: 1'b0,
                       ls_on: !(skip_mode_sel && !fb_s.above_early && fb_s.zero_current)
                              && !fb_s.neg_clamp,
                       hs_latch_off: 1'b0, ls_latch_off: 1'b0};
      end
   end

   AST_PG_LOW_ON_FAULT: assert property (@(posedge sys_clk) disable iff (!nrst)
      ok_latch_low_ff |=> !output_ok_flag_oe_n) else $error("output ok not low after latch");
   AST_PG_DEFAULT_LOW: assert property (@(posedge sys_clk) disable iff (!nrst)
      !ss_int_done |=> !output_ok_flag_oe_n) else $error("output ok high before soft-start");
   AST_UV_LATCH: assert property (@(posedge sys_clk) disable iff (!nrst)
      (uv_done && enable) |=> undervoltage_trip) else $error("uv not latched");
   AST_UV_GATED: assert property (@(posedge sys_clk) disable iff (!nrst)
      !ss_int_done |=> !uv_done) else $error("uv active during soft-start");
   AST_UV_RESTART: assert property (@(posedge sys_clk) disable iff (!nrst)
      !fb_s.below_uv |=> !uv_done) else $error("uv timer not reset");
   AST_FAULT_HOLD: assert property (@(posedge sys_clk) disable iff (!nrst)
      (fault_ff && enable) |=> fault_ff) else $error("fault cleared without toggle");
   AST_LATCH_OFF: assert property (@(posedge sys_clk) disable iff (!nrst)
      fault_ff |=> gate_cmd.hs_latch_off && gate_cmd.ls_latch_off) else $error("drivers not off");
   AST_DIS_STOP: assert property (@(posedge sys_clk) disable iff (!nrst)
      fb_s.below_dis |=> !discharge_on) else $error("discharge on below 90 mV");
   AST_EARLY_NOLATCH: assert property (@(posedge sys_clk) disable iff (!nrst)
      early_overvoltage_guard |-> !fault_ff || uv_done || undervoltage_trip) else $error("early ov latched");
   AST_FORCED_CONTINUOUS_OPERATION_EARLY: assert property (@(posedge sys_clk) disable iff (!nrst)
      fb_s.above_early |=> forced_continuous_operation) else $error("early ov not continuous");
   COV_PG_UP: cover property (@(posedge sys_clk) disable iff (!nrst) $rose(output_ok_flag_oe_n));
   COV_UV_TRIP: cover property (@(posedge sys_clk) disable iff (!nrst) $rose(undervoltage_trip));
   COV_OV_PULSE: cover property (@(posedge sys_clk) disable iff (!nrst) $rose(hs_pulse_ff));
   COV_DISCHARGE: cover property (@(posedge sys_clk) disable iff (!nrst) $rose(discharge_on));
endmodule

/* core/delay_timer.sv */
// qualification counter: done after LEN cycles of steady start, cleared on drop
`timescale 1ns/1ns
module delay_timer #(
   parameter int W   = 24,
   parameter int LEN = 100
) (
   input  wire logic sys_clk,
   input  wire logic nrst,
   input  wire logic start,
   output logic      done
);
   localparam logic [W-1:0] LAST = W'(LEN - 1);
   logic [W-1:0] cnt_ff;
   always_ff @(posedge sys_clk) begin
      if (!nrst || !start) begin
         cnt_ff <= '0;
         done   <= 1'b0;
      end else if (cnt_ff != LAST) begin
         cnt_ff <= cnt_ff + W'(1);
      end else begin
         done   <= 1'b1;
      end
   end
endmodule

/* core/fault_sup_pkg.sv */
// shared constants and carrier types for the converter fault supervisor
package fault_sup_pkg;
   localparam int CLK_HZ            = 50_000_000;
   localparam int OUTPUT_OK_FLAG_DELAY_NS    = 1_060_000;
   localparam int SS_RAMP_NS        = 2_000_000;
   localparam int PG_FAULT_NS       = 2_000;
   localparam int UV_DELAY_NS       = 68_000;
   localparam int PG_DELAY_CYC      = (OUTPUT_OK_FLAG_DELAY_NS / 1000) * (CLK_HZ / 1_000_000);
   localparam int SS_RAMP_CYC       = (SS_RAMP_NS / 1000) * (CLK_HZ / 1_000_000);
   localparam int PG_FAULT_CYC      = (PG_FAULT_NS * (CLK_HZ / 1_000_000)) / 1000;
   localparam int UV_DELAY_CYC      = (UV_DELAY_NS * (CLK_HZ / 1_000_000)) / 1000;
   localparam int CNT_W             = 24;
   localparam int SYNC_W            = 8;

   // comparator results on the feedback node and inductor current, plus high-side on-time expiry, already decided by the analog side
   typedef struct packed {
      logic below_uv;        // below 80% of internal_reference_level
      logic above_ov;        // above 116%
      logic above_early;     // above 105%
      logic near_ref;        // within 50 mV below reference
      logic below_dis;       // below 90 mV
      logic neg_clamp;       // negative_current_clamp reached
      logic on_time_done;    // high-side on-time expired
      logic zero_current;    // zero inductor current seen
   } fb_cmp_t;

   typedef struct packed {
      logic hs_on;
      logic ls_on;
      logic hs_latch_off;
      logic ls_latch_off;
   } gate_cmd_t;
endpackage

/* core/sync_stage.sv */
// two flip-flop synchroniser for a bundle of levels
`timescale 1ns/1ns
module sync_stage #(
   parameter int W = 8
) (
   input  wire logic         sys_clk,
   input  wire logic         nrst,
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);
   logic [W-1:0] meta_ff;
   always_ff @(posedge sys_clk) begin
      if (!nrst) begin
         meta_ff <= '0;
         q       <= '0;
      end else begin
         meta_ff <= d;
         q       <= meta_ff;
      end
   end
endmodule

/* tb/buck_fault_supervisor_tb.sv */
// self-checking bench for the converter fault supervisor
`timescale 1ns/1ns
module buck_fault_supervisor_tb;
   import fault_sup_pkg::*;
   localparam int PGD = 20;
   localparam int SSR = 30;
   logic       sys_clk, nrst, enable, bias_lockout, input_lockout, thermal_trip, skip_mode_sel;
   logic [2:0] fb_lvl;
   fb_cmp_t    fb_cmp;
   gate_cmd_t  gate_cmd;
   logic       ok_o, ok_oe_n, discharge_on, ss_pin_discharge, fco, uv_trip, ov_trip, early_g;
   int         mismatches, n_tests, n;

   buck_fault_supervisor #(.PG_DELAY(PGD), .SS_RAMP(SSR)) buck_fault_supervisor_inst (
      .sys_clk(sys_clk), .nrst(nrst), .enable(enable), .bias_lockout(bias_lockout),
      .input_lockout(input_lockout), .thermal_trip(thermal_trip), .skip_mode_sel(skip_mode_sel),
      .fb_cmp(fb_cmp), .output_ok_flag_o(ok_o), .output_ok_flag_oe_n(ok_oe_n), .gate_cmd(gate_cmd),
      .discharge_on(discharge_on), .ss_pin_discharge(ss_pin_discharge),
      .forced_continuous_operation(fco), .undervoltage_trip(uv_trip), .overvoltage_trip(ov_trip),
      .early_overvoltage_guard(early_g));

   converter_model converter_model_inst (.sys_clk(sys_clk), .gate_cmd(gate_cmd), .fb_lvl(fb_lvl),
      .fb_cmp(fb_cmp));

   initial begin
      sys_clk = 1'b0;
      forever #10 sys_clk = ~sys_clk;
   end

   task automatic conclude();
      $display("checks %0d mismatches %0d", n_tests, mismatches);
      if (mismatches == 0 && n_tests > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   task automatic chk(input string name, input logic exp, input logic got);
      n_tests++;
      if (got !== exp) begin
         mismatches++;
         $display("[FAIL] %s expected %b seen %b", name, exp, got);
      end
   endtask

   task automatic chk_rng(input string name, input int lo, input int hi, input int got);
      n_tests++;
      if (got < lo || got > hi) begin
         mismatches++;
         $display("[FAIL] %s expected %0d..%0d seen %0d", name, lo, hi, got);
      end
   endtask

   function automatic logic pick(input int sel);
      case (sel)
         0: pick = ok_oe_n;
         1: pick = uv_trip;
         2: pick = ov_trip;
         3: pick = discharge_on;
         default: pick = ss_pin_discharge;
      endcase
   endfunction

   // counts falling edges until the chosen output reaches val; a miss ends the run
   task automatic wait_for(input int sel, input logic val, input int lim, output int cyc);
      cyc = 0;
      while (pick(sel) !== val && cyc < lim) begin
         @(negedge sys_clk);
         cyc++;
      end
      if (pick(sel) !== val) begin
         mismatches++;
         $display("[FAIL] wait on output %0d expected %b seen %b", sel, val, pick(sel));
         conclude();
      end
   endtask

   task automatic idle(input int c);
      repeat (c) @(negedge sys_clk);
   endtask

   // enable low long enough to clear latches, then a full start-up
   task automatic start();
      enable = 1'b0;
      idle(4);
      enable = 1'b1;
      wait_for(0, 1'b1, 200, n);
      chk_rng("start delay", SSR + PGD, SSR + PGD + 8, n);
   endtask

   initial begin
      mismatches = 0;
      n_tests = 0;
      nrst = 1'b0;
      enable = 1'b0;
      bias_lockout = 1'b0;
      input_lockout = 1'b0;
      thermal_trip = 1'b0;
      skip_mode_sel = 1'b0;
      fb_lvl = 3'h1;
      idle(20);
      chk("oe_n reset", 1'b0, ok_oe_n);
      chk("hs latch reset", 1'b1, gate_cmd.hs_latch_off);
      chk("ss discharge reset", 1'b1, ss_pin_discharge);
      nrst = 1'b1;
      enable = 1'b1;
      idle(100);
      chk("oe_n below ref", 1'b0, ok_oe_n);
      chk("data pin", 1'b0, ok_o);
      $display("test reset and idle done");
      fb_lvl = 3'h2;
      start();
      skip_mode_sel = 1'b1;
      idle(4);
      chk("skip mode", 1'b0, fco);
      skip_mode_sel = 1'b0;
      idle(4);
      chk("forced mode", 1'b1, fco);
      skip_mode_sel = 1'b1;
      fb_lvl = 3'h3;
      idle(6);
      chk("early forces cont", 1'b1, fco);
      chk("early guard", 1'b1, early_g);
      chk("early no ov", 1'b0, ov_trip);
      chk("early keeps ok", 1'b1, ok_oe_n);
      fb_lvl = 3'h2;
      idle(6);
      chk("early released", 1'b0, fco);
      $display("test start and modes done");
      fb_lvl = 3'h1;
      wait_for(0, 1'b0, 200, n);
      chk_rng("ok fault delay", PG_FAULT_CYC, PG_FAULT_CYC + 8, n);
      idle(2900);
      fb_lvl = 3'h2;
      idle(10);
      chk("ok stays low", 1'b0, ok_oe_n);
      chk("uv not yet", 1'b0, uv_trip);
      fb_lvl = 3'h1;
      wait_for(1, 1'b1, UV_DELAY_CYC + 50, n);
      chk_rng("uv delay", UV_DELAY_CYC, UV_DELAY_CYC + 10, n);
      idle(2);
      chk("uv hs off", 1'b1, gate_cmd.hs_latch_off);
      chk("uv ls off", 1'b1, gate_cmd.ls_latch_off);
      fb_lvl = 3'h2;
      idle(10);
      chk("uv held", 1'b1, uv_trip);
      enable = 1'b0;
      wait_for(3, 1'b1, 8, n);
      chk("dis hs off", 1'b1, gate_cmd.hs_latch_off);
      fb_lvl = 3'h0;
      wait_for(3, 1'b0, 8, n);
      chk("uv cleared", 1'b0, uv_trip);
      $display("test undervoltage and discharge done");
      fb_lvl = 3'h2;
      start();
      fb_lvl = 3'h4;
      wait_for(2, 1'b1, 200, n);
      chk("ov hs off", 1'b0, gate_cmd.hs_on);
      wait_for(0, 1'b0, 200, n);
      chk_rng("ov ok delay", PG_FAULT_CYC - 4, PG_FAULT_CYC + 8, n);
      chk("ov ok low", 1'b0, ok_oe_n);
      fb_lvl = 3'h1;
      wait_for(1, 1'b1, UV_DELAY_CYC + 50, n);
      idle(2);
      chk("ov end ls off", 1'b1, gate_cmd.ls_latch_off);
      $display("test overvoltage done");
      for (int i = 0; i < 3; i++) begin
         fb_lvl = 3'h2;
         start();
         bias_lockout = (i == 0);
         input_lockout = (i == 1);
         thermal_trip = (i == 2);
         wait_for(3, 1'b1, 8, n);
         chk("ss pin discharged", 1'b1, ss_pin_discharge);
         bias_lockout = 1'b0;
         input_lockout = 1'b0;
         thermal_trip = 1'b0;
         wait_for(4, 1'b0, 8, n);
      end
      $display("test lockouts done");
      conclude();
   end
endmodule

/* tb/converter_model.sv */
// behavioural power stage and feedback comparators facing the supervisor
`timescale 1ns/1ns
module converter_model
   import fault_sup_pkg::*;
(
   input  wire logic       sys_clk,
   input  wire gate_cmd_t  gate_cmd,
   input  wire logic [2:0] fb_lvl,
   output fb_cmp_t         fb_cmp
);
   logic [2:0] ls_cnt_ff = 3'h0;
   logic [2:0] hs_cnt_ff = 3'h0;

   // saturating on-time counters stand in for inductor current build-up
   always_ff @(posedge sys_clk) begin
      ls_cnt_ff <= gate_cmd.ls_on ? ((ls_cnt_ff == 3'h7) ? ls_cnt_ff : ls_cnt_ff + 3'h1) : 3'h0;
      hs_cnt_ff <= gate_cmd.hs_on ? ((hs_cnt_ff == 3'h7) ? hs_cnt_ff : hs_cnt_ff + 3'h1) : 3'h0;
   end

   // fb_lvl: 0 near ground, 1 under threshold, 2 at reference, 3 early high, 4 overvoltage
   always_comb begin
      fb_cmp.below_uv     = (fb_lvl <= 3'h1);
      fb_cmp.below_dis    = (fb_lvl == 3'h0);
      fb_cmp.near_ref     = (fb_lvl >= 3'h2);
      fb_cmp.above_early  = (fb_lvl >= 3'h3);
      fb_cmp.above_ov     = (fb_lvl == 3'h4);
      // clamp is only reached while the output sits high and current runs negative
      fb_cmp.neg_clamp    = (ls_cnt_ff >= 3'h4) && (fb_lvl >= 3'h3);
      fb_cmp.on_time_done = (hs_cnt_ff >= 3'h3);
      fb_cmp.zero_current = (ls_cnt_ff >= 3'h2) && (fb_lvl <= 3'h2);
   end
endmodule
